/* File: src/ppc_map.svh */
// register offsets, field positions, reset values and timing counts for port power control
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

`define PPC_PWR_CTRL_OFFSET 8'h1c
`define PPC_LINE_STATUS_OFFSET 8'h1d
`define PPC_BIT_QUICK_SWAP 7
`define PPC_BIT_MON_DIS_N 6
`define PPC_BIT_ALARM_DIS 5
`define PPC_BIT_AUTO_DISCH 4
`define PPC_BIT_BLEED 3
`define PPC_BIT_FORCE_DISCH 2
`define PPC_BIT_SUPPLY_LEVEL 1
`define PPC_BIT_SUPPLY_EN 0
`define PPC_PWR_CTRL_RESET 8'h60
`define PPC_PWR_CTRL_WMASK 8'h77
`define PPC_LINE_STATUS_RESET 8'h00
`define PPC_LINE_OPEN 2'h0
`define PPC_ROLE_OPEN 2'h3
`define PPC_CLK_MHZ 250
`define PPC_DEBOUNCE_US 375
`define PPC_UPDATE_US 50
`define PPC_DEBOUNCE_CYCLES (`PPC_DEBOUNCE_US * `PPC_CLK_MHZ)
`define PPC_UPDATE_CYCLES (`PPC_UPDATE_US * `PPC_CLK_MHZ)

`endif

/* File: src/ppc_pkg.sv */
// types shared by the port power control block
package ppc_pkg;
    typedef enum logic [1:0] {
        DIS_IDLE,
        DIS_STOP_SRC,
        DIS_DISCHARGE
    } ppc_dis_state_type;
    typedef logic [1:0] ppc_line_type;
endpackage : ppc_pkg

/* File: src/ppc_sync.sv */
// two flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
`default_nettype none
module ppc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk_i, // system clock
    input wire logic reset_i, // synchronous reset
    input wire logic ce_i, // clock enable
    input wire logic [WIDTH-1:0] async_i, // pin levels
    output logic [WIDTH-1:0] sync_o // synchronised levels
);
    logic [WIDTH-1:0] meta_ff; // first stage, read only by second stage

    // two stage capture of outside levels
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_ff <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            meta_ff <= async_i;
            sync_o <= meta_ff;
        end
    end
endmodule : ppc_sync
`default_nettype wire

/* File: src/ppc_debounce.sv */
// debounce filter for one two bit line state
`timescale 1ns/10ps
`include "ppc_map.svh"
`default_nettype none
module ppc_debounce #(
    parameter int DEBOUNCE_CYCLES = `PPC_DEBOUNCE_CYCLES
) (
    input wire logic ref_clk_i, // system clock
    input wire logic reset_i, // synchronous reset
    input wire logic ce_i, // clock enable
    input wire logic [1:0] raw_i, // synchronised raw state
    output logic [1:0] stable_o, // debounced state
    output logic change_o // pulse when stable state changes
);
    logic [1:0] cand_ff; // candidate value being timed
    logic [16:0] cnt_ff; // stability counter

    // hold the candidate until it has been steady long enough
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cand_ff <= `PPC_LINE_OPEN;
            cnt_ff <= '0;
            stable_o <= `PPC_LINE_OPEN;
            change_o <= 1'b0;
        end else if (ce_i) begin
            change_o <= 1'b0;
            if (raw_i != cand_ff) begin
                cand_ff <= raw_i;
                cnt_ff <= '0;
            end else if (cnt_ff < 17'(DEBOUNCE_CYCLES - 1)) begin
                cnt_ff <= cnt_ff + 17'h1;
            end else if (stable_o != cand_ff) begin
                stable_o <= cand_ff;
                change_o <= 1'b1;
            end
        end
    end
endmodule : ppc_debounce
`default_nettype wire

/* File: src/ppc_port_power.sv */
// power control register, line status register and discharge sequencing
`timescale 1ns/10ps
`include "ppc_map.svh"
`default_nettype none
module ppc_port_power (
    input wire logic ref_clk_i, // 250 MHz system clock
    input wire logic reset_i, // synchronous reset, active high
    input wire logic ce_i, // clock enable, freezes state when low
    input wire logic reg_wr_i, // register write strobe, one cycle
    input wire logic reg_rd_i, // register read strobe, one cycle
    input wire logic [7:0] reg_addr_i, // register offset
    input wire logic [7:0] reg_wdata_i, // write data
    output logic [7:0] reg_rdata_o, // read data, valid cycle after read
    output logic reg_rvalid_o, // read data valid pulse
    input wire logic [1:0] line_one_raw_i, // pin state of config line one
    input wire logic [1:0] line_two_raw_i, // pin state of config line two
    input wire logic plug_orientation_i, // orientation, 0 line one active
    input wire logic [1:0] role_line_one_i, // role setting line one
    input wire logic [1:0] role_line_two_i, // role setting line two
    input wire logic shield_short_protection_i, // shield protection active
    input wire logic fault_action_a_i, // fault action A in force
    output logic bus_monitor_on_o, // adc monitoring of bus enabled
    output logic voltage_alarm_on_o, // voltage alarm reporting enabled
    output logic bus_source_on_o, // permission to source bus voltage
    output logic bus_discharge_o, // bus discharge switch on
    output logic connector_supply_on_o, // connector supply switch on
    output logic line_one_supply_o, // supply routed to line one
    output logic status_change_o // pulse, a debounced line state changed while reporting is on
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and debounce

    logic [5:0] pins_sync; // synchronised pin levels
    logic [1:0] deb_one; // debounced line one
    logic [1:0] deb_two; // debounced line two
    logic chg_one; // line one changed
    logic chg_two; // line two changed

    // raw lines, orientation and shield come from outside the clock domain
    ppc_sync #(.WIDTH(6)) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .async_i({shield_short_protection_i, plug_orientation_i,
                  line_two_raw_i, line_one_raw_i}),
        .sync_o(pins_sync)
    );

    logic shield_s; // synchronised shield state
    logic orient_s; // synchronised orientation
    assign shield_s = pins_sync[5];
    assign orient_s = pins_sync[4];

    // one debounce filter per line
    ppc_debounce u_deb_one (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .raw_i(pins_sync[1:0]),
        .stable_o(deb_one),
        .change_o(chg_one)
    );
    ppc_debounce u_deb_two (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .raw_i(pins_sync[3:2]),
        .stable_o(deb_two),
        .change_o(chg_two)
    );

    ////////////////////////////////////////////////////////////////////////
    // power control register

    logic [7:0] pwr_ctrl_ff; // stored power control bits
    logic [7:0] pend_data_ff; // write held during fault action A
    logic pend_ff; // a held write is waiting
    logic [7:0] nxt_pwr_ctrl; // next power control value
    logic wr_ctrl; // write aimed at power control

    // merge a host write, keeping unsupported bits at zero
    function automatic logic [7:0] ppc_merge(input logic [7:0] wd);
        ppc_merge = wd & `PPC_PWR_CTRL_WMASK;
    endfunction : ppc_merge

    assign wr_ctrl = reg_wr_i && (reg_addr_i == `PPC_PWR_CTRL_OFFSET);

    // hold writes that arrive while fault action A is in force
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pend_ff <= 1'b0;
            pend_data_ff <= `PPC_PWR_CTRL_RESET;
        end else if (ce_i) begin
            if (wr_ctrl && fault_action_a_i) begin
                pend_ff <= 1'b1;
                pend_data_ff <= reg_wdata_i;
            end else if (!fault_action_a_i) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // next value: pending or live write, then shield clear
    always_comb begin
        nxt_pwr_ctrl = pwr_ctrl_ff;
        if (!fault_action_a_i) begin
            if (wr_ctrl) begin
                nxt_pwr_ctrl = ppc_merge(reg_wdata_i);
            end else if (pend_ff) begin
                nxt_pwr_ctrl = ppc_merge(pend_data_ff);
            end
        end
        if (shield_s) begin
            nxt_pwr_ctrl[`PPC_BIT_SUPPLY_EN] = 1'b0;
        end
    end

    // only shield protection clears the supply enable by itself
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pwr_ctrl_ff <= `PPC_PWR_CTRL_RESET;
        end else if (ce_i) begin
            pwr_ctrl_ff <= nxt_pwr_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line status register

    logic [7:0] line_status_ff; // reported line status
    logic [7:0] nxt_line_status; // next reported status
    logic report_off; // both roles open
    ppc_pkg::ppc_line_type eff_one; // line one after supply override
    ppc_pkg::ppc_line_type eff_two; // line two after supply override

    assign report_off = (role_line_one_i == `PPC_ROLE_OPEN)
                     && (role_line_two_i == `PPC_ROLE_OPEN);

    // the line carrying supply reads open
    always_comb begin
        eff_one = deb_one;
        eff_two = deb_two;
        if (pwr_ctrl_ff[`PPC_BIT_SUPPLY_EN]) begin
            if (orient_s) begin
                eff_one = `PPC_LINE_OPEN;
            end else begin
                eff_two = `PPC_LINE_OPEN;
            end
        end
        nxt_line_status = {4'h0, eff_two, eff_one};
        if (report_off) begin
            nxt_line_status = `PPC_LINE_STATUS_RESET;
        end
    end

    // device owned register, refreshed every cycle, well inside the limit
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            line_status_ff <= `PPC_LINE_STATUS_RESET;
            status_change_o <= 1'b0;
        end else if (ce_i) begin
            line_status_ff <= nxt_line_status;
            // alert side sees only real line changes, not reporting off
            status_change_o <= (chg_one || chg_two) && !report_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // detach detection and discharge sequence

    ppc_pkg::ppc_dis_state_type dis_state_ff; // discharge sequence state
    logic detach; // active line reads open

    // host must set orientation before the enable
    assign detach = orient_s ? (deb_two == `PPC_LINE_OPEN)
                             : (deb_one == `PPC_LINE_OPEN);

    // stop sourcing first, then discharge
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            dis_state_ff <= ppc_pkg::DIS_IDLE;
        end else if (ce_i) begin
            case (dis_state_ff)
                ppc_pkg::DIS_IDLE: begin
                    if (pwr_ctrl_ff[`PPC_BIT_AUTO_DISCH] && detach) begin
                        dis_state_ff <= ppc_pkg::DIS_STOP_SRC;
                    end
                end
                ppc_pkg::DIS_STOP_SRC: begin
                    dis_state_ff <= ppc_pkg::DIS_DISCHARGE;
                end
                ppc_pkg::DIS_DISCHARGE: begin
                    if (!detach || !pwr_ctrl_ff[`PPC_BIT_AUTO_DISCH]) begin
                        dis_state_ff <= ppc_pkg::DIS_IDLE;
                    end
                end
                default: begin
                    dis_state_ff <= ppc_pkg::DIS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs and read port

    // registered drive of the power path; supply level bit feeds nothing
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            bus_monitor_on_o <= 1'b0;
            voltage_alarm_on_o <= 1'b0;
            bus_source_on_o <= 1'b1;
            bus_discharge_o <= 1'b0;
            connector_supply_on_o <= 1'b0;
            line_one_supply_o <= 1'b0;
        end else if (ce_i) begin
            bus_monitor_on_o <= !pwr_ctrl_ff[`PPC_BIT_MON_DIS_N];
            voltage_alarm_on_o <= !pwr_ctrl_ff[`PPC_BIT_ALARM_DIS];
            bus_source_on_o <= (dis_state_ff == ppc_pkg::DIS_IDLE);
            bus_discharge_o <= pwr_ctrl_ff[`PPC_BIT_FORCE_DISCH]
                            || (dis_state_ff == ppc_pkg::DIS_DISCHARGE);
            connector_supply_on_o <= pwr_ctrl_ff[`PPC_BIT_SUPPLY_EN];
            line_one_supply_o <= orient_s;
        end
    end

    // read answer one cycle after the strobe, unmapped reads zero
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `PPC_PWR_CTRL_OFFSET: reg_rdata_o <= pwr_ctrl_ff;
                    `PPC_LINE_STATUS_OFFSET: reg_rdata_o <= line_status_ff;
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_reserved_zero;
        @(posedge ref_clk_i) disable iff (reset_i)
        pwr_ctrl_ff[`PPC_BIT_QUICK_SWAP] == 1'b0 && pwr_ctrl_ff[`PPC_BIT_BLEED] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_monitor;
        @(posedge ref_clk_i) disable iff (reset_i)
        ce_i |=> bus_monitor_on_o == !$past(pwr_ctrl_ff[`PPC_BIT_MON_DIS_N]);
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor polarity wrong");

    property p_alarm;
        @(posedge ref_clk_i) disable iff (reset_i)
        ce_i |=> voltage_alarm_on_o == !$past(pwr_ctrl_ff[`PPC_BIT_ALARM_DIS]);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm polarity wrong");

    sequence s_detach_seen;
        ce_i && dis_state_ff == ppc_pkg::DIS_IDLE
            && pwr_ctrl_ff[`PPC_BIT_AUTO_DISCH] && detach;
    endsequence
    property p_auto_seq;
        @(posedge ref_clk_i) disable iff (reset_i)
        s_detach_seen ##1 ce_i |=> !bus_source_on_o;
    endproperty
    a_auto_seq: assert property (p_auto_seq) else $error("sourcing not stopped");

    property p_no_disch_while_src;
        @(posedge ref_clk_i) disable iff (reset_i)
        (dis_state_ff == ppc_pkg::DIS_DISCHARGE) |-> $past(dis_state_ff) != ppc_pkg::DIS_IDLE;
    endproperty
    a_no_disch_while_src: assert property (p_no_disch_while_src) else $error("skipped stop");

    property p_shield;
        @(posedge ref_clk_i) disable iff (reset_i)
        (ce_i && shield_s) |=> !pwr_ctrl_ff[`PPC_BIT_SUPPLY_EN];
    endproperty
    a_shield: assert property (p_shield) else $error("supply kept on under shield");

    property p_report_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        (ce_i && report_off) |=> line_status_ff == 8'h00;
    endproperty
    a_report_off: assert property (p_report_off) else $error("status not zeroed");

    property p_fault_block;
        @(posedge ref_clk_i) disable iff (reset_i)
        (ce_i && fault_action_a_i && !shield_s) |=> $stable(pwr_ctrl_ff);
    endproperty
    a_fault_block: assert property (p_fault_block) else $error("write during fault");

    // look at what the host really reads back, not at the stored constant bits
    property p_status_high_zero;
        @(posedge ref_clk_i) disable iff (reset_i)
        (reg_rvalid_o && $past(ce_i) && $past(reg_addr_i) == `PPC_LINE_STATUS_OFFSET)
            |-> reg_rdata_o[7:4] == 4'h0;
    endproperty
    a_status_high_zero: assert property (p_status_high_zero) else $error("status top set");
endmodule : ppc_port_power
`default_nettype wire

/* File: tb/ppc_host.sv */
// host model driving the register strobes of the port power block
`timescale 1ns/10ps
`default_nettype none
module ppc_host (
    input wire logic ref_clk_i, // system clock
    output logic reg_wr_o, // write strobe
    output logic reg_rd_o, // read strobe
    output logic [7:0] reg_addr_o, // register offset
    output logic [7:0] reg_wdata_o, // write data
    input wire logic [7:0] reg_rdata_i, // read data
    input wire logic reg_rvalid_i // read data valid
);
    // idle bus at time zero
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one byte write, released lines show the inverse of the last value
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
    endtask : write_reg
    // one byte read, waits a bounded time for the valid pulse
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        int n;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= addr;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        n = 0;
        #1;
        while (reg_rvalid_i !== 1'b1 && n < 4) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        ok = (reg_rvalid_i === 1'b1);
        data = reg_rdata_i;
    endtask : read_reg
endmodule : ppc_host
`default_nettype wire

/* File: tb/test_port_power_control_and_cc_status.sv */
// self-checking bench for the port power control block
`timescale 1ns/10ps
`default_nettype none
module test_port_power_control_and_cc_status;
    logic ref_clk_i; // system clock
    logic reset_i; // synchronous reset
    logic wr, rd, rvalid, orient, shield, fault; // strobes and controls
    logic [7:0] addr, wdata, rdata; // register bus
    logic [1:0] raw1, raw2, role1, role2; // line pins and roles
    logic mon_on, alarm_on, src_on, disch, sup_on, sup_one, chg; // outputs
    int n_fail, checks, cyc; // counters
    logic [31:0] seed; // xorshift state
    ////////////////////////////////////////////////////////////////////////////
    ppc_port_power uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .line_one_raw_i(raw1),
        .line_two_raw_i(raw2), .plug_orientation_i(orient), .role_line_one_i(role1),
        .role_line_two_i(role2), .shield_short_protection_i(shield),
        .fault_action_a_i(fault), .bus_monitor_on_o(mon_on), .voltage_alarm_on_o(alarm_on),
        .bus_source_on_o(src_on), .bus_discharge_o(disch), .connector_supply_on_o(sup_on),
        .line_one_supply_o(sup_one), .status_change_o(chg));
    ppc_host host (.ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
    ////////////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // hang guard, a little above the long debounce wait
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 97000) begin
            n_fail++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    // stored value of the power control register after a write
    function automatic logic [7:0] pwr_exp(input logic [7:0] w);
        return w & 8'h77;
    endfunction : pwr_exp
    // status byte from the two line states
    function automatic logic [7:0] stat_exp(input logic [1:0] l2, input logic [1:0] l1);
        return {4'h0, l2, l1};
    endfunction : stat_exp
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check8
    task automatic check1(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask : check1
    task automatic rd_expect(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        logic ok;
        host.read_reg(a, d, ok);
        check1("read_valid", 1'b1, ok);
        check8(name, exp, d);
    endtask : rd_expect
    task automatic final_report();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] w, last;
        int n;
        seed = 32'h0001663c;
        n_fail = 0;
        checks = 0;
        cyc = 0;
        reset_i = 1'b1;
        {orient, shield, fault} = 3'h0;
        {raw1, raw2} = 4'h0;
        role1 = 2'h1;
        role2 = 2'h1;
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd_expect(8'h1c, 8'h60, "power_reset");
        check1("monitor_reset", 1'b0, mon_on);
        check1("source_reset", 1'b1, src_on);
        rd_expect(8'h1d, 8'h00, "status_reset");
        // random writes with corners, auto discharge kept off here
        last = 8'h60;
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd();
            w = w & 8'hef;
            host.write_reg(8'h1c, w);
            rd_expect(8'h1c, pwr_exp(w), "power_rw");
            check1("monitor_on", ~w[6], mon_on);
            check1("alarm_on", ~w[5], alarm_on);
            check1("forced_discharge", w[2], disch);
            check1("supply_on", w[0], sup_on);
            last = pwr_exp(w);
        end
        host.write_reg(8'h1d, 8'hff);
        rd_expect(8'h1d, 8'h00, "status_readonly");
        rd_expect(8'h3f, 8'h00, "unmapped");
        // write held while fault action is in force
        @(posedge ref_clk_i);
        fault <= 1'b1;
        host.write_reg(8'h1c, 8'h64);
        rd_expect(8'h1c, last, "fault_hold");
        fault <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rd_expect(8'h1c, 8'h64, "fault_release");
        // orientation already 0 and line one open: detach seen
        host.write_reg(8'h1c, 8'h70);
        n = 0;
        while (src_on !== 1'b0 && n < 8) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check1("stop_source", 1'b0, src_on);
        check1("discharge_after_stop", 1'b0, disch);
        repeat (3) @(posedge ref_clk_i);
        #1;
        check1("auto_discharge", 1'b1, disch);
        host.write_reg(8'h1c, 8'h60);
        repeat (3) @(posedge ref_clk_i);
        #1;
        check1("discharge_end", 1'b0, disch);
        check1("source_back", 1'b1, src_on);
        // shield protection clears supply enable
        host.write_reg(8'h1c, 8'h61);
        shield <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        #1;
        check1("shield_supply", 1'b0, sup_on);
        rd_expect(8'h1c, 8'h60, "shield_clear");
        shield <= 1'b0;
        // both lines change together, timed against debounce and update
        raw1 <= 2'h2;
        raw2 <= 2'h1;
        n = 0;
        while (chg !== 1'b1 && n < 95000) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check1("update_window", 1'b1, (n >= 93750) && (n <= 93750 + 12500));
        rd_expect(8'h1d, stat_exp(2'h1, 2'h2), "line_status");
        @(posedge ref_clk_i);
        role1 <= 2'h3;
        role2 <= 2'h3;
        rd_expect(8'h1d, 8'h00, "reporting_off");
        role1 <= 2'h1;
        rd_expect(8'h1d, stat_exp(2'h1, 2'h2), "reporting_on");
        // supply forces the line opposite the orientation open
        host.write_reg(8'h1c, 8'h61);
        repeat (4) @(posedge ref_clk_i);
        rd_expect(8'h1d, stat_exp(2'h0, 2'h2), "supply_line_two");
        orient <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        #1;
        check1("supply_route", 1'b1, sup_one);
        rd_expect(8'h1d, stat_exp(2'h1, 2'h0), "supply_line_one");
        check1("supply_kept", 1'b1, sup_on);
        // active line attached: auto discharge stays idle
        orient <= 1'b0;
        host.write_reg(8'h1c, 8'h71);
        repeat (6) @(posedge ref_clk_i);
        #1;
        check1("no_detach", 1'b1, src_on);
        final_report();
    end
endmodule : test_port_power_control_and_cc_status
`default_nettype wire
